// ===== hdl/pwm_fault_pkg.sv
package pwm_fault_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFS_FAULT_CONTROL     = 4'h0;
  localparam logic [3:0] OFS_FAULT_STATUS      = 4'h1;
  localparam logic [3:0] OFS_FAULT_ACKNOWLEDGE = 4'h2;
  localparam logic [3:0] OFS_OUTPUT_OVERRIDE   = 4'h3;
  localparam logic [3:0] OFS_PWM_CONTROL       = 4'h4;
  localparam logic [3:0] OFS_DEADTIME_SENSE    = 4'h5;
  localparam logic [3:0] OFS_DISABLE_MAPPING   = 4'h6;
  localparam logic [3:0] OFS_MODULUS           = 4'h7;
  localparam logic [3:0] OFS_DUTY_A            = 4'h8;
  localparam logic [3:0] OFS_DUTY_B            = 4'h9;
  localparam logic [3:0] OFS_DUTY_C            = 4'ha;
  localparam logic [3:0] OFS_DEADTIME          = 4'hb;

  // Field positions
  localparam int OVR_ENABLE_BIT  = 6;
  localparam int CTL_ENABLE_BIT  = 0;
  localparam int CTL_COMP_BIT    = 1;
  localparam int CTL_CENTER_BIT  = 2;

  // Reset values
  localparam logic [7:0] RST_FAULT_CONTROL   = 8'h00;
  localparam logic [7:0] RST_OUTPUT_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_PWM_CONTROL     = 8'h00;
  localparam logic [7:0] RST_DISABLE_MAPPING = 8'hff;
  localparam logic [7:0] RST_MODULUS         = 8'h00;
  localparam logic [7:0] RST_DUTY            = 8'h00;
  localparam logic [7:0] RST_DEADTIME        = 8'h00;

  // Counter step per PWM clock tick, no prescaler
  localparam logic [7:0] COUNT_STEP = 8'h01;

  typedef enum logic {
    count_up   = 1'b0,
    count_down = 1'b1
  } dir_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_type;

  typedef struct packed {
    logic [3:0]      fsync1;
    logic [3:0]      fsync2;
    logic [3:0]      fprev;
    logic [2:0]      ssync1;
    logic [2:0]      ssync2;
    logic [3:0]      fmode;
    logic [3:0]      firq_en;
    logic [3:0]      flag;
    logic [3:0]      auto_hold;
    logic            manual_output_enable;
    logic [5:0]      level;
    logic            enable;
    logic            comp;
    logic            center;
    logic [7:0]      disable_mapping;
    logic            disable_mapping_locked;
    logic [7:0]      modulus;
    logic [7:0]      deadtime;
    logic [2:0][7:0] duty;
    logic [7:0]      cnt;
    dir_type         dir;
    logic [5:0]      out_q;
    logic [5:0][7:0] dt_cnt;
    logic [5:0]      dt_sense;
    logic [5:0]      pin;
    logic [5:0]      pin_oe;
    logic            irq;
    logic [7:0]      rdata;
  } state_type;

endpackage : pwm_fault_pkg

// ===== hdl/pwm_fault_override.sv
// Function
// R1 - Per-input fault mode: 1 automatic, 0 manual
// R2 - Per-input interrupt enable bit
// R3 - Faults disable mapped outputs regardless of interrupts
// R4 - Status shows present fault input level
// R5 - Rising fault edge sets sticky event flag
// R6 - Writing 1 to acknowledge clears that flag
// R7 - Acknowledge bits always read zero
// R8 - Sense bits sampled just before dead-time ends
// R9 - Manual enable feeds outputs from level bits
// R10 - Generator counter keeps running under manual control
// R11 - Clearing manual enable reconnects generator at once
// R12 - Even or independent level bits set active
// R13 - Complementary odd bit: own level bit while even partner off, else off
// R14 - One PWM tick equals one bus cycle
// R15 - Center-aligned period is twice modulus ticks
// R16 - Edge-aligned period is modulus ticks
// R17 - Disable mapping is write-once until reset
// R18 - Pins released while disabled unless manual control
// R19 - Interrupt request while enabled flag set
// R20 - Manual waits for acknowledge; automatic releases at cycle start
`timescale 1ns/1ns

module pwm_fault_override (
  input  wire logic                        ref_clk,
  input  wire logic                        nrst,
  input  wire pwm_fault_pkg::reg_req_type  bus_req,
  output logic [pwm_fault_pkg::DATA_W-1:0] rdata,
  input  wire logic [3:0]                  fault_in,
  input  wire logic                        current_sense_a,
  input  wire logic                        current_sense_b,
  input  wire logic                        current_sense_c,
  output logic                             pwm_out_a_top,
  output logic                             pwm_out_a_bottom,
  output logic                             pwm_out_b_top,
  output logic                             pwm_out_b_bottom,
  output logic                             pwm_out_c_top,
  output logic                             pwm_out_c_bottom,
  output logic                             pwm_oe_a_top,
  output logic                             pwm_oe_a_bottom,
  output logic                             pwm_oe_b_top,
  output logic                             pwm_oe_b_bottom,
  output logic                             pwm_oe_c_top,
  output logic                             pwm_oe_c_bottom,
  output logic                             fault_irq
);

  import pwm_fault_pkg::*;

  state_type  st;
  state_type  next_st;
  logic [3:0] fault_rise;
  logic [3:0] fault_active;
  logic [5:0] want;
  logic [5:0] disabled;
  logic [2:0] gen;
  logic       cycle_start;
  logic       wr_ack;
  logic [7:0] rd_mux;

  always_comb begin
    next_st = st;
    // Pin synchronisers
    next_st.fsync1 = fault_in;
    next_st.fsync2 = st.fsync1;
    next_st.fprev  = st.fsync2;
    next_st.ssync1 = {current_sense_c, current_sense_b, current_sense_a};
    next_st.ssync2 = st.ssync1;
    fault_rise = st.fsync2 & ~st.fprev;
    wr_ack = bus_req.wr && (bus_req.addr == OFS_FAULT_ACKNOWLEDGE);

    // Register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_FAULT_CONTROL: begin
          for (int i = 0; i < 4; i++) begin
            next_st.fmode[i]   = bus_req.wdata[2*i];   // [R1]
            next_st.firq_en[i] = bus_req.wdata[2*i+1]; // [R2]
          end
        end
        OFS_OUTPUT_OVERRIDE: begin
          next_st.manual_output_enable = bus_req.wdata[OVR_ENABLE_BIT];
          next_st.level  = bus_req.wdata[5:0];
        end
        OFS_PWM_CONTROL: begin
          next_st.enable = bus_req.wdata[CTL_ENABLE_BIT];
          next_st.comp   = bus_req.wdata[CTL_COMP_BIT];
          next_st.center = bus_req.wdata[CTL_CENTER_BIT];
        end
        OFS_DISABLE_MAPPING: begin
          if (!st.disable_mapping_locked) begin // [R17]
            next_st.disable_mapping        = bus_req.wdata;
            next_st.disable_mapping_locked = 1'b1;
          end
        end
        OFS_MODULUS: next_st.modulus = bus_req.wdata;
        OFS_DUTY_A:  next_st.duty[0] = bus_req.wdata;
        OFS_DUTY_B:  next_st.duty[1] = bus_req.wdata;
        OFS_DUTY_C:  next_st.duty[2] = bus_req.wdata;
        OFS_DEADTIME: next_st.deadtime = bus_req.wdata;
        default: begin
        end
      endcase
    end

    // Counter, one step per bus cycle
    cycle_start = 1'b0;
    if (!st.enable || st.modulus == 8'h00) begin
      next_st.cnt = 8'h00;
      next_st.dir = count_up;
      cycle_start = 1'b1;
    end else if (st.center) begin // [R15]
      case (st.dir)
        count_up: begin
          next_st.cnt = st.cnt + COUNT_STEP; // [R14]
          if (st.cnt == st.modulus - COUNT_STEP) begin
            next_st.dir = count_down;
          end
        end
        count_down: begin
          next_st.cnt = st.cnt - COUNT_STEP;
          if (st.cnt == COUNT_STEP) begin
            next_st.dir = count_up;
            cycle_start = 1'b1;
          end
        end
        default: next_st.dir = count_up;
      endcase
    end else begin // [R16]
      next_st.dir = count_up;
      if (st.cnt >= st.modulus - COUNT_STEP) begin
        next_st.cnt = 8'h00;
        cycle_start = 1'b1;
      end else begin
        next_st.cnt = st.cnt + COUNT_STEP; // [R14]
      end
    end

    // Fault flags and hold state
    for (int i = 0; i < 4; i++) begin
      if (wr_ack && bus_req.wdata[i]) begin
        next_st.flag[i] = 1'b0; // [R6]
      end
      if (fault_rise[i]) begin
        next_st.flag[i] = 1'b1; // [R5]
      end
      if (st.fsync2[i]) begin
        next_st.auto_hold[i] = 1'b1;
      end else if (cycle_start) begin
        next_st.auto_hold[i] = 1'b0; // [R20]
      end
      fault_active[i] = st.fmode[i] ? (st.auto_hold[i] | st.fsync2[i])
                                    : (st.flag[i] | st.fsync2[i]); // [R20]
    end
    disabled = (|fault_active) ? st.disable_mapping[5:0] : 6'h00; // [R3]

    // Generator compare, keeps running whatever the source
    for (int p = 0; p < 3; p++) begin
      gen[p] = st.cnt < st.duty[p]; // [R10]
    end

    // Source select per pair
    for (int p = 0; p < 3; p++) begin
      if (st.manual_output_enable) begin // [R9]
        want[2*p] = st.level[2*p]; // [R12]
        if (st.comp) begin
          want[2*p+1] = st.level[2*p+1] & ~st.level[2*p]; // [R13]
        end else begin
          want[2*p+1] = st.level[2*p+1]; // [R12]
        end
      end else begin // [R11]
        want[2*p]   = gen[p];
        want[2*p+1] = st.comp ? ~gen[p] : gen[p];
      end
    end

    // Dead-time insertion and sense capture
    for (int i = 0; i < 6; i++) begin
      if (!want[i]) begin
        next_st.out_q[i]  = 1'b0;
        next_st.dt_cnt[i] = st.deadtime;
      end else if (!st.out_q[i]) begin
        if (!st.comp || st.dt_cnt[i] == 8'h00) begin
          next_st.out_q[i] = 1'b1;
          if (st.comp) begin
            next_st.dt_sense[i] = st.ssync2[i/2]; // [R8]
          end
        end else begin
          next_st.dt_cnt[i] = st.dt_cnt[i] - COUNT_STEP;
        end
      end
    end

    // Pins
    next_st.pin    = st.out_q & ~disabled; // [R3]
    next_st.pin_oe = (st.enable || st.manual_output_enable) ? 6'h3f : 6'h00; // [R18]
    next_st.irq    = |(st.flag & st.firq_en); // [R2] [R19]

    // Read data, valid only the cycle after the strobe
    rd_mux = 8'h00;
    case (bus_req.addr)
      OFS_FAULT_CONTROL: begin
        for (int i = 0; i < 4; i++) begin
          rd_mux[2*i]   = st.fmode[i];
          rd_mux[2*i+1] = st.firq_en[i];
        end
      end
      OFS_FAULT_STATUS: begin
        for (int i = 0; i < 4; i++) begin
          rd_mux[2*i]   = st.flag[i];
          rd_mux[2*i+1] = st.fsync2[i]; // [R4]
        end
      end
      OFS_FAULT_ACKNOWLEDGE: rd_mux = 8'h00; // [R7]
      OFS_OUTPUT_OVERRIDE: begin
        rd_mux[OVR_ENABLE_BIT] = st.manual_output_enable;
        rd_mux[5:0]            = st.level;
      end
      OFS_PWM_CONTROL: begin
        rd_mux[CTL_ENABLE_BIT] = st.enable;
        rd_mux[CTL_COMP_BIT]   = st.comp;
        rd_mux[CTL_CENTER_BIT] = st.center;
      end
      OFS_DEADTIME_SENSE:  rd_mux[5:0] = st.dt_sense; // [R8]
      OFS_DISABLE_MAPPING: rd_mux = st.disable_mapping;
      OFS_MODULUS:         rd_mux = st.modulus;
      OFS_DUTY_A:          rd_mux = st.duty[0];
      OFS_DUTY_B:          rd_mux = st.duty[1];
      OFS_DUTY_C:          rd_mux = st.duty[2];
      OFS_DEADTIME:        rd_mux = st.deadtime;
      default:             rd_mux = 8'h00;
    endcase
    next_st.rdata = bus_req.rd ? rd_mux : 8'h00;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st               <= '0;
      st.fmode         <= RST_FAULT_CONTROL[3:0];
      st.firq_en       <= RST_FAULT_CONTROL[7:4];
      st.manual_output_enable        <= RST_OUTPUT_OVERRIDE[OVR_ENABLE_BIT];
      st.level         <= RST_OUTPUT_OVERRIDE[5:0];
      st.enable        <= RST_PWM_CONTROL[CTL_ENABLE_BIT];
      st.comp          <= RST_PWM_CONTROL[CTL_COMP_BIT];
      st.center        <= RST_PWM_CONTROL[CTL_CENTER_BIT];
      st.disable_mapping        <= RST_DISABLE_MAPPING;
      st.modulus       <= RST_MODULUS;
      st.deadtime      <= RST_DEADTIME;
      st.duty          <= {3{RST_DUTY}};
      st.dir           <= count_up;
    end else begin
      st <= next_st;
    end
  end

  assign rdata            = st.rdata;
  assign pwm_out_a_top    = st.pin[0];
  assign pwm_out_a_bottom = st.pin[1];
  assign pwm_out_b_top    = st.pin[2];
  assign pwm_out_b_bottom = st.pin[3];
  assign pwm_out_c_top    = st.pin[4];
  assign pwm_out_c_bottom = st.pin[5];
  assign pwm_oe_a_top     = st.pin_oe[0];
  assign pwm_oe_a_bottom  = st.pin_oe[1];
  assign pwm_oe_b_top     = st.pin_oe[2];
  assign pwm_oe_b_bottom  = st.pin_oe[3];
  assign pwm_oe_c_top     = st.pin_oe[4];
  assign pwm_oe_c_bottom  = st.pin_oe[5];
  assign fault_irq        = st.irq;

endmodule : pwm_fault_override

// ===== bench/gate_driver_model.sv
`timescale 1ns/1ns
module gate_driver_model (
  input  wire logic       ref_clk,
  input  wire logic [3:0] fault_cmd,
  input  wire logic [5:0] drive,
  input  wire logic [5:0] drive_oe,
  output logic      [3:0] fault_in,
  output logic      [2:0] sense
);
  // Fault sensors follow the commanded fault conditions
  assign fault_in = fault_cmd;
  initial sense = 3'h2;
  // Phase current from the bottom gates; with all outputs undriven, sense toggles every cycle
  always @(posedge ref_clk) begin
    sense <= (drive_oe != 6'h00) ? {drive[5], drive[3], drive[1]} : ~sense;
  end
endmodule : gate_driver_model

// ===== bench/pwm_fault_monitor.sv
`timescale 1ns/1ns
module pwm_fault_monitor (
  input wire logic                       ref_clk,
  input wire logic                       nrst,
  input wire pwm_fault_pkg::reg_req_type bus_req,
  input wire logic [7:0]                 rdata,
  input wire logic [3:0]                 fault_in,
  input wire logic                       pwm_out_a_top,
  input wire logic                       pwm_out_a_bottom,
  input wire logic                       pwm_out_b_top,
  input wire logic                       pwm_out_b_bottom,
  input wire logic                       pwm_out_c_top,
  input wire logic                       pwm_out_c_bottom,
  input wire logic                       pwm_oe_a_top,
  input wire logic                       pwm_oe_a_bottom,
  input wire logic                       pwm_oe_b_top,
  input wire logic                       pwm_oe_b_bottom,
  input wire logic                       pwm_oe_c_top,
  input wire logic                       pwm_oe_c_bottom,
  input wire logic                       fault_irq
);
  import pwm_fault_pkg::*;
  logic [7:0]  fault_control, ovr, ctl, dm;
  logic        lock;
  logic [3:0]  pend, ien;
  logic [4:0]  quiet;
  logic [5:0]  pins, oe, lvl;
  logic [15:0] hit;
  assign pins = {pwm_out_c_bottom, pwm_out_c_top, pwm_out_b_bottom, pwm_out_b_top, pwm_out_a_bottom, pwm_out_a_top};
  assign oe = {pwm_oe_c_bottom, pwm_oe_c_top, pwm_oe_b_bottom, pwm_oe_b_top, pwm_oe_a_bottom, pwm_oe_a_top};
  assign lvl = ovr[5:0];
  assign ien = {fault_control[7], fault_control[5], fault_control[3], fault_control[1]};
  assign hit = bus_req.wr ? (16'h0001 << bus_req.addr) : 16'h0000;
  // Shadow of the fault control, override, PWM control and disable mapping registers and of unacknowledged faults
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      {fault_control, ovr, ctl, lock, pend, quiet} <= '0;
      dm <= 8'hff;
    end else begin
      if (hit[OFS_FAULT_CONTROL]) fault_control <= bus_req.wdata;
      if (hit[OFS_OUTPUT_OVERRIDE]) ovr <= bus_req.wdata;
      if (hit[OFS_PWM_CONTROL]) ctl <= bus_req.wdata;
      if (hit[OFS_DISABLE_MAPPING] && !lock) dm <= bus_req.wdata;
      if (hit[OFS_DISABLE_MAPPING]) lock <= 1'b1;
      pend <= (pend & ~(hit[OFS_FAULT_ACKNOWLEDGE] ? bus_req.wdata[3:0] : 4'h0)) | fault_in;
      quiet <= (bus_req.wr || fault_in != 4'h0 || pend != 4'h0) ? 5'h00 : quiet + 5'(quiet < 5'd20);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ack_zero_a: assert property (
    bus_req.rd && bus_req.addr == OFS_FAULT_ACKNOWLEDGE |=> rdata == 8'h00) else $error("ack read nonzero");
  ctl_readback_a: assert property (
    bus_req.rd && bus_req.addr == OFS_FAULT_CONTROL |=> rdata == $past(fault_control)) else $error("control readback");
  map_once_a: assert property (
    bus_req.rd && bus_req.addr == OFS_DISABLE_MAPPING |=> rdata[5:0] == $past(dm[5:0])) else $error("mapping");
  fault_masks_a: assert property (
    |(fault_in & ~$past(fault_in)) ##1 (fault_in != 4'h0) [*2] |-> ##[0:3] (pins & dm[5:0]) == 6'h00)
    else $error("fault did not mask");
  irq_cause_a: assert property (
    fault_irq |-> ($past(pend & ien) != 4'h0)) else $error("irq without enabled event");
  irq_prompt_a: assert property (
    |(fault_in & ~$past(fault_in) & ien) |-> ##[1:4] fault_irq) else $error("irq late");
  oe_follow_a: assert property (
    oe == {6{$past(ctl[CTL_ENABLE_BIT] | ovr[OVR_ENABLE_BIT])}}) else $error("enable mismatch");
  manual_lvl_a: assert property (
    quiet > 5'd12 && ovr[OVR_ENABLE_BIT] |-> pins == (ctl[CTL_COMP_BIT] ? lvl & ~({lvl[4:0], 1'b0} & 6'h2a) : lvl))
    else $error("manual level");
  cover property ($rose(fault_irq));
  cover property (quiet > 5'd12 && ovr[OVR_ENABLE_BIT]);
  cover property (lock && hit[OFS_DISABLE_MAPPING]);
endmodule : pwm_fault_monitor
bind pwm_fault_override pwm_fault_monitor pwm_fault_monitor_i (.*);

// ===== bench/pwm_fault_override_tb.sv
`timescale 1ns/1ns
module pwm_fault_override_tb;
  import pwm_fault_pkg::*;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  reg_req_type req = '0;
  logic [3:0]  flt = 4'h0;
  logic [3:0]  fault_in;
  logic [2:0]  sense;
  logic [7:0]  rdata;
  logic [5:0]  pins, oe;
  logic        fault_irq;
  logic [5:0]  pats [4] = '{6'h3f, 6'h15, 6'h2a, 6'h03};
  int          miscompares = 0;
  int          samples_checked = 0;
  always #25 ref_clk = ~ref_clk;
  pwm_fault_override pwm_fault_override_i (
    .ref_clk(ref_clk), .nrst(nrst), .bus_req(req), .rdata(rdata), .fault_in(fault_in),
    .current_sense_a(sense[0]), .current_sense_b(sense[1]), .current_sense_c(sense[2]),
    .pwm_out_a_top(pins[0]), .pwm_out_a_bottom(pins[1]), .pwm_out_b_top(pins[2]),
    .pwm_out_b_bottom(pins[3]), .pwm_out_c_top(pins[4]), .pwm_out_c_bottom(pins[5]),
    .pwm_oe_a_top(oe[0]), .pwm_oe_a_bottom(oe[1]), .pwm_oe_b_top(oe[2]),
    .pwm_oe_b_bottom(oe[3]), .pwm_oe_c_top(oe[4]), .pwm_oe_c_bottom(oe[5]), .fault_irq(fault_irq));
  gate_driver_model gate_driver_model_i (
    .ref_clk(ref_clk), .fault_cmd(flt), .drive(pins), .drive_oe(oe), .fault_in(fault_in), .sense(sense));
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    tick;
    req.wr <= 1'b0;
    tick;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    req.addr <= a;
    req.rd <= 1'b1;
    tick;
    req.rd <= 1'b0;
    chk(rdata, e);
    tick;
  endtask : rd
  task automatic wait_pins(input logic [5:0] e, input int n);
    for (int i = 0; i < n && pins !== e; i++) tick;
    chk({2'b00, pins}, {2'b00, e});
  endtask : wait_pins
  task automatic period(input logic [7:0] e);
    int n;
    n = 0;
    do begin tick; n++; end while (pins[0] !== 1'b0 && n < 20);
    do begin tick; n++; end while (pins[0] !== 1'b1 && n < 40);
    n = 0;
    do begin tick; n++; end while (pins[0] !== 1'b0 && n < 20);
    do begin tick; n++; end while (pins[0] !== 1'b1 && n < 20);
    chk(8'(n), e);
  endtask : period
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (6) tick;
    nrst <= 1'b1;
    tick;
    rd(OFS_FAULT_CONTROL, 8'h00);
    rd(OFS_FAULT_ACKNOWLEDGE, 8'h00);
    rd(OFS_DISABLE_MAPPING, 8'hff);
    rd(4'hf, 8'h00);
    chk({2'b00, oe}, 8'h00);
    wr(OFS_DISABLE_MAPPING, 8'h15);
    wr(OFS_DISABLE_MAPPING, 8'h3f);
    rd(OFS_DISABLE_MAPPING, 8'h15);
    wr(OFS_FAULT_CONTROL, 8'h12);
    rd(OFS_FAULT_CONTROL, 8'h12);
    wr(OFS_OUTPUT_OVERRIDE, 8'h7f);
    wait_pins(6'h3f, 4);
    chk({2'b00, oe}, 8'h3f);
    flt <= 4'h2;
    repeat (5) tick;
    chk({7'h00, fault_irq}, 8'h00);
    chk({2'b00, pins}, 8'h2a);
    flt <= 4'h3;
    for (int i = 0; i < 4 && fault_irq !== 1'b1; i++) tick;
    chk({7'h00, fault_irq}, 8'h01);
    rd(OFS_FAULT_STATUS, 8'h0f);
    flt <= 4'h0;
    repeat (4) tick;
    wr(OFS_FAULT_ACKNOWLEDGE, 8'h00);
    rd(OFS_FAULT_STATUS, 8'h05);
    wr(OFS_FAULT_ACKNOWLEDGE, 8'h01);
    rd(OFS_FAULT_STATUS, 8'h04);
    chk({fault_irq, pins}, 8'h2a);
    wr(OFS_FAULT_ACKNOWLEDGE, 8'h02);
    wait_pins(6'h3f, 4);
    wr(OFS_MODULUS, 8'h04);
    wr(OFS_DUTY_A, 8'h02);
    wr(OFS_PWM_CONTROL, 8'h01);
    flt <= 4'h4;
    wait_pins(6'h2a, 5);
    flt <= 4'h0;
    wait_pins(6'h3f, 12);
    rd(OFS_FAULT_STATUS, 8'h10);
    wr(OFS_FAULT_ACKNOWLEDGE, 8'h04);
    wr(OFS_PWM_CONTROL, 8'h03);
    foreach (pats[k]) begin
      wr(OFS_OUTPUT_OVERRIDE, {2'b01, pats[k]});
      wait_pins(pats[k] & ~({pats[k][4:0], 1'b0} & 6'h2a), 4);
      repeat (4) tick;
    end
    repeat (14) tick;
    rd(OFS_DEADTIME_SENSE, 8'h01);
    wr(OFS_PWM_CONTROL, 8'h01);
    wr(OFS_OUTPUT_OVERRIDE, 8'h00);
    period(8'd4);
    wr(OFS_PWM_CONTROL, 8'h05);
    repeat (10) tick;
    period(8'd8);
    wr(OFS_PWM_CONTROL, 8'h00);
    repeat (3) tick;
    chk({2'b00, oe}, 8'h00);
    final_report;
  end
endmodule : pwm_fault_override_tb
